// [design/iacl_clr_decode.sv]
// decoder turning a clear-code write into per-channel clear pulses
`default_nettype none
module iacl_clr_decode (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic wr_in,
    input wire logic [3:0] code_in,
    output logic [1:0] clr_out
);
    function automatic logic [1:0] decode(input logic [3:0] c);
        case (c)
            iacl_pkg::CODE_CLR_CH0: decode = 2'h1;
            iacl_pkg::CODE_CLR_CH1: decode = 2'h2;
            iacl_pkg::CODE_CLR_BOTH: decode = 2'h3;
            default: decode = 2'h0; // prohibited and invalid codes
        endcase
    endfunction : decode

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            clr_out <= 2'h0;
        end else if (ce_in) begin
            clr_out <= wr_in ? decode(code_in) : 2'h0;
        end
    end

    a_bad_code_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && wr_in && (code_in[3] || code_in[2:0] < 3'h5) |=> clr_out == 2'h0)
        else $error("clear pulse from bad code");
    a_code_ch0: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && wr_in && code_in == iacl_pkg::CODE_CLR_CH0 |=> clr_out == 2'h1)
        else $error("channel 0 clear missing");
endmodule : iacl_clr_decode
`default_nettype wire

// [design/iacl_edge_det.sv]
// falling edge detector for the channel 0 clock pin
`default_nettype none
module iacl_edge_det (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic pin_in,
    output logic fall_out
);
    logic prev;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            prev <= 1'b1;
        end else if (ce_in) begin
            prev <= pin_in;
        end
    end
    assign fall_out = ce_in && prev && !pin_in;
endmodule : iacl_edge_det
`default_nettype wire

// [design/iacl_top.sv]
// acknowledge bit store and format switch / latch clear register
// Notes on behaviour
// - checked transmit, peer high ack sets stored ack bit.
// - low ack when checked, or writing check enable zero, clears it.
// - during reception drive the reply ack value after each byte.
// - read gives bus-captured ack when transmitting, else reply value.
// - any ack bit write replaces the reply value regardless of mode.
// - switch enabled and channel 0 clock falls sets flag and interrupt.
// - flag clears only by writing zero after reading it one.
// - codes 0101, 0110, 0111 clear channel 0, 1, both.
// - valid code write pulses the chosen channels' latch clear.
// - clear code bits are write-only and read back as ones.
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`default_nettype none
module iacl_top (
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic CE_IN,
    // axi4-lite slave
    input wire logic [7:0] AWADDR_IN,
    input wire logic AWVALID_IN,
    output logic AWREADY_OUT,
    input wire logic [31:0] WDATA_IN,
    input wire logic [3:0] WSTRB_IN,
    input wire logic WVALID_IN,
    output logic WREADY_OUT,
    output logic [1:0] BRESP_OUT,
    output logic BVALID_OUT,
    input wire logic BREADY_IN,
    input wire logic [7:0] ARADDR_IN,
    input wire logic ARVALID_IN,
    output logic ARREADY_OUT,
    output logic [31:0] RDATA_OUT,
    output logic [1:0] RRESP_OUT,
    output logic RVALID_OUT,
    input wire logic RREADY_IN,
    // acknowledge slot from the byte engine
    input wire logic ACK_SLOT_IN,
    input wire logic ACK_SDA_IN,
    // channel 0 clock pin level
    input wire logic SCL0_IN,
    output logic ACK_DRIVE_OUT,
    output logic ACK_SDA_OE_OUT,
    output logic CLR_CH0_OUT,
    output logic CLR_CH1_OUT,
    output logic IRQ_OUT
);
    logic ack_check_enable;
    logic transmit_select;
    logic format_switch_enable;
    logic ack_captured;
    logic ack_bit_value;
    logic sw_flag;
    logic sw_flag_seen;
    logic [2:0] rsv;
    logic [2:0] int_stat;
    logic [2:0] int_en;
    logic scl_fall;
    logic [1:0] clr_pulse;
    logic clr_wr;
    logic [3:0] clr_code;
    logic rd_fire;
    logic [7:0] raddr;

    // write channel capture: address and data may arrive in either order
    iacl_pkg::iacl_bus_e wstate;
    logic aw_have;
    logic w_have;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic wr_fire;

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            waddr <= 8'h00;
            wdata <= 32'h0;
            AWREADY_OUT <= 1'b0;
            WREADY_OUT <= 1'b0;
            BVALID_OUT <= 1'b0;
            BRESP_OUT <= iacl_pkg::AXI_OKAY;
            wstate <= iacl_pkg::BS_IDLE;
        end else if (CE_IN) begin
            AWREADY_OUT <= 1'b0;
            WREADY_OUT <= 1'b0;
            case (wstate)
                iacl_pkg::BS_IDLE: begin
                    if (AWVALID_IN && !aw_have && !AWREADY_OUT) begin
                        AWREADY_OUT <= 1'b1;
                        aw_have <= 1'b1;
                        waddr <= AWADDR_IN;
                    end
                    if (WVALID_IN && !w_have && !WREADY_OUT) begin
                        WREADY_OUT <= 1'b1;
                        w_have <= 1'b1;
                        wdata <= WDATA_IN;
                    end
                    if (aw_have && w_have) begin
                        wstate <= iacl_pkg::BS_RESP;
                    end
                end
                iacl_pkg::BS_RESP: begin
                    BVALID_OUT <= 1'b1;
                    BRESP_OUT <= known(waddr) ? iacl_pkg::AXI_OKAY
                                              : iacl_pkg::AXI_SLVERR;
                    aw_have <= 1'b0;
                    w_have <= 1'b0;
                    wstate <= iacl_pkg::BS_WAIT;
                end
                iacl_pkg::BS_WAIT: begin
                    if (BREADY_IN) begin
                        BVALID_OUT <= 1'b0;
                        wstate <= iacl_pkg::BS_IDLE;
                    end
                end
                default: wstate <= iacl_pkg::BS_IDLE;
            endcase
        end
    end

    function automatic logic known(input logic [7:0] a);
        known = a == iacl_pkg::OFF_STATUS || a == iacl_pkg::OFF_CTRL ||
                a == iacl_pkg::OFF_SWCLR || a == iacl_pkg::OFF_INT_STAT ||
                a == iacl_pkg::OFF_INT_EN || a == iacl_pkg::OFF_INT_CLR;
    endfunction : known

    // registers update in the cycle that the response is raised
    assign wr_fire = CE_IN && wstate == iacl_pkg::BS_RESP;

    function automatic logic wr_to(input logic [7:0] off);
        wr_to = wr_fire && waddr == off && WSTRB_IN_low();
    endfunction : wr_to

    // byte lane 0 carries every field here
    function automatic logic WSTRB_IN_low();
        WSTRB_IN_low = 1'b1;
    endfunction : WSTRB_IN_low

    // control register
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            ack_check_enable <= 1'b0;
            transmit_select <= 1'b0;
            format_switch_enable <= 1'b0;
        end else if (wr_to(iacl_pkg::OFF_CTRL)) begin
            ack_check_enable <= wdata[iacl_pkg::BIT_ACK_CHECK_ENABLE];
            transmit_select <= wdata[iacl_pkg::BIT_TRS];
            format_switch_enable <= wdata[iacl_pkg::BIT_SWE];
        end
    end

    // reply value written by software
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            ack_bit_value <= 1'b0;
        end else if (wr_to(iacl_pkg::OFF_STATUS)) begin
            ack_bit_value <= wdata[iacl_pkg::BIT_ACK];
        end
    end

    // acknowledge captured from the peer while transmitting
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            ack_captured <= 1'b0;
        end else if (CE_IN) begin
            if (wr_to(iacl_pkg::OFF_CTRL) && !wdata[iacl_pkg::BIT_ACK_CHECK_ENABLE]) begin
                ack_captured <= 1'b0;
            end else if (ACK_SLOT_IN && transmit_select && ack_check_enable) begin
                ack_captured <= ACK_SDA_IN;
            end
        end
    end

    // reply drive during reception: open drain, low pulls the line
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            ACK_DRIVE_OUT <= 1'b1;
            ACK_SDA_OE_OUT <= 1'b0;
        end else if (CE_IN) begin
            ACK_DRIVE_OUT <= ack_bit_value;
            ACK_SDA_OE_OUT <= ACK_SLOT_IN && !transmit_select && !ack_bit_value;
        end
    end

    // format switch and clear register
    iacl_edge_det u_edge (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .ce_in(CE_IN),
        .pin_in(SCL0_IN),
        .fall_out(scl_fall)
    );

    assign clr_wr = wr_to(iacl_pkg::OFF_SWCLR);
    assign clr_code = wdata[3:0];

    iacl_clr_decode u_clr (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .ce_in(CE_IN),
        .wr_in(clr_wr),
        .code_in(clr_code),
        .clr_out(clr_pulse)
    );

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            CLR_CH0_OUT <= 1'b0;
            CLR_CH1_OUT <= 1'b0;
        end else if (CE_IN) begin
            CLR_CH0_OUT <= clr_pulse[0];
            CLR_CH1_OUT <= clr_pulse[1];
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            rsv <= iacl_pkg::SWCLR_RSV_RESET;
        end else if (clr_wr) begin
            rsv <= wdata[7:5];
        end
    end

    // flag: set wins over clear; clear needs an earlier read of one
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            sw_flag <= 1'b0;
            sw_flag_seen <= 1'b0;
        end else if (CE_IN) begin
            if (format_switch_enable && scl_fall) begin
                sw_flag <= 1'b1;
            end else if (clr_wr && sw_flag_seen &&
                         !wdata[iacl_pkg::BIT_SWFLAG]) begin
                sw_flag <= 1'b0;
                sw_flag_seen <= 1'b0;
            end
            if (rd_fire && raddr == iacl_pkg::OFF_SWCLR && sw_flag) begin
                sw_flag_seen <= 1'b1;
            end
        end
    end

    // interrupt status: sticky, write-one-to-clear, set wins
    logic [2:0] int_set;
    assign int_set = {1'b0, ACK_SLOT_IN && transmit_select &&
                      ack_check_enable && ACK_SDA_IN,
                      format_switch_enable && scl_fall};
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            int_stat <= 3'h0;
        end else if (CE_IN) begin
            int_stat <= (int_stat &
                ~(wr_to(iacl_pkg::OFF_INT_CLR) ? wdata[2:0] : 3'h0)) |
                int_set;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            int_en <= 3'h0;
        end else if (wr_to(iacl_pkg::OFF_INT_EN)) begin
            int_en <= wdata[2:0];
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            IRQ_OUT <= 1'b0;
        end else if (CE_IN) begin
            IRQ_OUT <= |(int_stat & int_en);
        end
    end

    // read channel: one cycle to accept, data on the next
    logic [31:0] rword;
    assign rd_fire = CE_IN && ARVALID_IN && ARREADY_OUT;

    always_comb begin
        rword = 32'h0;
        case (raddr)
            iacl_pkg::OFF_STATUS:
                rword[iacl_pkg::BIT_ACK] = transmit_select ? ack_captured
                                                           : ack_bit_value;
            iacl_pkg::OFF_CTRL:
                rword[2:0] = {format_switch_enable, transmit_select,
                              ack_check_enable};
            iacl_pkg::OFF_SWCLR:
                rword[7:0] = {rsv, sw_flag, iacl_pkg::CLR_READ_VALUE};
            iacl_pkg::OFF_INT_STAT: rword[2:0] = int_stat;
            iacl_pkg::OFF_INT_EN: rword[2:0] = int_en;
            default: rword = 32'h0;
        endcase
    end

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            ARREADY_OUT <= 1'b0;
            RVALID_OUT <= 1'b0;
            RDATA_OUT <= 32'h0;
            RRESP_OUT <= iacl_pkg::AXI_OKAY;
            raddr <= 8'h00;
        end else if (CE_IN) begin
            ARREADY_OUT <= ARVALID_IN && !ARREADY_OUT && !RVALID_OUT;
            if (ARVALID_IN && !ARREADY_OUT && !RVALID_OUT) begin
                raddr <= ARADDR_IN;
            end
            if (rd_fire) begin
                RVALID_OUT <= 1'b1;
                RDATA_OUT <= rword;
                RRESP_OUT <= (known(raddr) && raddr != iacl_pkg::OFF_INT_CLR)
                             ? iacl_pkg::AXI_OKAY : iacl_pkg::AXI_SLVERR;
            end else if (RVALID_OUT && RREADY_IN) begin
                RVALID_OUT <= 1'b0;
            end
        end
    end

    a_ack_set_high: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        CE_IN && ACK_SLOT_IN && transmit_select && ack_check_enable &&
        ACK_SDA_IN && !wr_to(iacl_pkg::OFF_CTRL) |=> ack_captured)
        else $error("high ack not stored");
    a_ack_check_enable_clear: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        wr_to(iacl_pkg::OFF_CTRL) && !wdata[iacl_pkg::BIT_ACK_CHECK_ENABLE]
        |=> !ack_captured)
        else $error("ack not cleared by check enable");
    a_reply_drive: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        CE_IN && ACK_SLOT_IN && !transmit_select
        |=> ACK_SDA_OE_OUT == !$past(ack_bit_value))
        else $error("reply ack drive wrong");
    a_reply_write: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        wr_to(iacl_pkg::OFF_STATUS) |=> ack_bit_value == $past(wdata[0]))
        else $error("reply value not replaced");
    sequence s_sw_event;
        CE_IN && format_switch_enable && scl_fall;
    endsequence
    a_sw_flag_set: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        s_sw_event |=> sw_flag ##1 (IRQ_OUT || !int_en[iacl_pkg::INT_SW]))
        else $error("switch flag or irq missing");
    a_sw_flag_hold: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        sw_flag && !sw_flag_seen |=> sw_flag)
        else $error("flag cleared without read");
    a_clr_read_ones: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        rd_fire && raddr == iacl_pkg::OFF_SWCLR |=> RDATA_OUT[3:0] == 4'hf)
        else $error("clear code bits not ones");
    a_clr_both: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        CE_IN && clr_wr && clr_code == iacl_pkg::CODE_CLR_BOTH
        |=> ##1 CLR_CH0_OUT && CLR_CH1_OUT)
        else $error("both channel clear missing");
endmodule : iacl_top
`default_nettype wire

// [shared/iacl_pkg.sv]
// constants shared by the ack and latch-clear block
`default_nettype none
package iacl_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_SWCLR = 8'h08;
    localparam logic [7:0] OFF_INT_STAT = 8'h0c;
    localparam logic [7:0] OFF_INT_EN = 8'h10;
    localparam logic [7:0] OFF_INT_CLR = 8'h14;
    // bit positions
    localparam int BIT_ACK = 0;
    localparam int BIT_ACK_CHECK_ENABLE = 0;
    localparam int BIT_TRS = 1;
    localparam int BIT_SWE = 2;
    localparam int BIT_SWFLAG = 4;
    // reset and read-back values
    localparam logic [2:0] SWCLR_RSV_RESET = 3'h0;
    localparam logic [3:0] CLR_READ_VALUE = 4'hf;
    // clear codes
    localparam logic [3:0] CODE_CLR_CH0 = 4'h5;
    localparam logic [3:0] CODE_CLR_CH1 = 4'h6;
    localparam logic [3:0] CODE_CLR_BOTH = 4'h7;
    // interrupt status bits
    localparam int INT_SW = 0;
    localparam int INT_NACK = 1;
    localparam int INT_W = 2;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        BS_IDLE = 3'h1,
        BS_RESP = 3'h2,
        BS_WAIT = 3'h4
    } iacl_bus_e;
endpackage : iacl_pkg
`default_nettype wire

// [verification/iacl_peer_model.sv]
// bus peer model: ack slot levels and channel 0 clock falls
`default_nettype none
module iacl_peer_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic go_in,
    input wire logic level_in,
    input wire logic [2:0] lag_in,
    input wire logic fall_in,
    output logic slot_out,
    output logic sda_out,
    output logic scl_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic pend;
    logic lvl;
    logic [2:0] lag;
    logic [1:0] slot;
    logic [1:0] low;
    // lag lets the peer answer promptly or slowly
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pend <= 1'b0;
            slot <= 2'h0;
        end else if (go_in) begin
            pend <= 1'b1;
            lag <= lag_in;
            lvl <= level_in;
        end else if (pend && lag != 3'h0) begin
            lag <= lag - 3'h1;
        end else if (pend) begin
            pend <= 1'b0;
            slot <= 2'h3;
        end else if (slot != 2'h0) begin
            slot <= slot - 2'h1;
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            low <= 2'h0;
        end else if (fall_in) begin
            low <= 2'h2;
        end else if (low != 2'h0) begin
            low <= low - 2'h1;
        end
    end
    assign slot_out = (slot != 2'h0);
    // released data line goes to its pull-up level
    assign sda_out = slot_out ? lvl : 1'b1;
    assign scl_out = (low == 2'h0);
endmodule : iacl_peer_model
`default_nettype wire

// [verification/tb_i2c_ack_and_latch_clear.sv]
// self-checking bench for the ack store and latch clear block
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    err_total++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_i2c_ack_and_latch_clear;
    timeunit 1ns;
    timeprecision 100ps;
    int err_total = 0;
    int checked = 0;
    int n0 = 0;
    int n1 = 0;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic go = 1'b0, lvl = 1'b0, fall = 1'b0;
    logic [2:0] lag = 3'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic slot, sda, scl, drive, oe, latch_clear_code_b0, latch_clear_code_b1, irq;
    logic [5:0] rows [8] = '{6'h00, 6'h15, 6'h0c, 6'h1a, 6'h10,
        6'h1f, 6'h20, 6'h3c};
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        if (latch_clear_code_b0 === 1'b1) n0 <= n0 + 1;
        if (latch_clear_code_b1 === 1'b1) n1 <= n1 + 1;
    end
    iacl_top dut (.MCLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1),
        .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
        .WDATA_IN(wdata), .WSTRB_IN(4'hf), .WVALID_IN(wvalid),
        .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid),
        .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid),
        .ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp),
        .RVALID_OUT(rvalid), .RREADY_IN(rready), .ACK_SLOT_IN(slot),
        .ACK_SDA_IN(sda), .SCL0_IN(scl), .ACK_DRIVE_OUT(drive),
        .ACK_SDA_OE_OUT(oe), .CLR_CH0_OUT(latch_clear_code_b0), .CLR_CH1_OUT(latch_clear_code_b1),
        .IRQ_OUT(irq));
    iacl_peer_model peer (.clk_in(clk), .rst_in(rst), .go_in(go),
        .level_in(lvl), .lag_in(lag), .fall_in(fall), .slot_out(slot),
        .sda_out(sda), .scl_out(scl));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (awready === 1'b1 && !aw_ok) begin
                awvalid <= 1'b0;
                aw_ok = 1'b1;
            end
            if (wready === 1'b1 && !w_ok) begin
                wvalid <= 1'b0;
                w_ok = 1'b1;
            end
        end
        while (bvalid !== 1'b1) @(posedge clk);
        `CHK(bresp, er)
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
            input logic [31:0] e, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk);
        `CHK(rresp, er)
        `CHK(rdata & m, e)
    endtask : rdchk
    // peer ack slot; the device pulls low only when replying zero
    task automatic ack(input logic level, input logic want_oe);
        go <= 1'b1;
        lvl <= level;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk iff slot);
        #1 `CHK(oe, want_oe)
        @(posedge clk iff !slot);
        #1 `CHK(oe, 1'b0)
        @(posedge clk);
    endtask : ack
    task automatic fall_edge();
        fall <= 1'b1;
        @(posedge clk);
        fall <= 1'b0;
        cyc(6);
    endtask : fall_edge
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
    initial begin
        cyc(20);
        rst <= 1'b0;
        @(posedge clk);
        `CHK(drive, 1'b1)
        `CHK({oe, latch_clear_code_b0, latch_clear_code_b1, irq}, 4'h0)
        rdchk(iacl_pkg::OFF_SWCLR, 32'hffffffff, 32'h0f, 2'h0);
        // table of clear codes, prohibited ones between the valid ones
        foreach (rows[i]) begin
            n0 = 0;
            n1 = 0;
            wr(iacl_pkg::OFF_SWCLR, {28'h0, rows[i][5:2]},
                iacl_pkg::AXI_OKAY);
            cyc(4);
            `CHK(n0, int'(rows[i][0]))
            `CHK(n1, int'(rows[i][1]))
            rdchk(iacl_pkg::OFF_SWCLR, 32'hffffffff, 32'h0f,
                iacl_pkg::AXI_OKAY);
        end
        wr(iacl_pkg::OFF_CTRL, 32'h3, iacl_pkg::AXI_OKAY);
        ack(1'b1, 1'b0);
        rdchk(iacl_pkg::OFF_STATUS, 32'h1, 32'h1, 2'h0);
        rdchk(iacl_pkg::OFF_INT_STAT, 32'h2, 32'h2, 2'h0);
        lag <= 3'h5;
        ack(1'b0, 1'b0);
        rdchk(iacl_pkg::OFF_STATUS, 32'h1, 32'h0, 2'h0);
        ack(1'b1, 1'b0);
        rdchk(iacl_pkg::OFF_STATUS, 32'h1, 32'h1, 2'h0);
        wr(iacl_pkg::OFF_CTRL, 32'h2, iacl_pkg::AXI_OKAY);
        rdchk(iacl_pkg::OFF_STATUS, 32'h1, 32'h0, 2'h0);
        ack(1'b1, 1'b0);
        rdchk(iacl_pkg::OFF_STATUS, 32'h1, 32'h0, 2'h0);
        // reply written while still transmitting
        wr(iacl_pkg::OFF_STATUS, 32'h0, iacl_pkg::AXI_OKAY);
        @(posedge clk);
        `CHK(drive, 1'b0)
        wr(iacl_pkg::OFF_CTRL, 32'h0, iacl_pkg::AXI_OKAY);
        rdchk(iacl_pkg::OFF_STATUS, 32'h1, 32'h0, 2'h0);
        ack(1'b1, 1'b1);
        wr(iacl_pkg::OFF_STATUS, 32'h1, iacl_pkg::AXI_OKAY);
        @(posedge clk);
        `CHK(drive, 1'b1)
        rdchk(iacl_pkg::OFF_STATUS, 32'h1, 32'h1, 2'h0);
        lag <= 3'h0;
        ack(1'b0, 1'b0);
        wr(iacl_pkg::OFF_CTRL, 32'h4, iacl_pkg::AXI_OKAY);
        wr(iacl_pkg::OFF_INT_EN, 32'h1, iacl_pkg::AXI_OKAY);
        `CHK(irq, 1'b0)
        fall_edge();
        `CHK(irq, 1'b1)
        rdchk(iacl_pkg::OFF_INT_STAT, 32'h1, 32'h1, 2'h0);
        // zero written before any read of the set flag must not clear it
        wr(iacl_pkg::OFF_SWCLR, 32'h0, iacl_pkg::AXI_OKAY);
        rdchk(iacl_pkg::OFF_SWCLR, 32'hff, 32'h1f, 2'h0);
        wr(iacl_pkg::OFF_SWCLR, 32'h0, iacl_pkg::AXI_OKAY);
        rdchk(iacl_pkg::OFF_SWCLR, 32'hff, 32'h0f, 2'h0);
        wr(iacl_pkg::OFF_INT_EN, 32'h0, iacl_pkg::AXI_OKAY);
        cyc(2);
        `CHK(irq, 1'b0)
        wr(iacl_pkg::OFF_INT_CLR, 32'h1, iacl_pkg::AXI_OKAY);
        rdchk(iacl_pkg::OFF_INT_STAT, 32'h1, 32'h0, 2'h0);
        wr(iacl_pkg::OFF_INT_EN, 32'h1, iacl_pkg::AXI_OKAY);
        cyc(2);
        `CHK(irq, 1'b0)
        wr(iacl_pkg::OFF_CTRL, 32'h0, iacl_pkg::AXI_OKAY);
        fall_edge();
        rdchk(iacl_pkg::OFF_SWCLR, 32'hff, 32'h0f, 2'h0);
        `CHK(irq, 1'b0)
        wr(8'h18, 32'h5, iacl_pkg::AXI_SLVERR);
        rdchk(8'h18, 32'hffffffff, 32'h0, iacl_pkg::AXI_SLVERR);
        rdchk(iacl_pkg::OFF_INT_CLR, 32'hffffffff, 32'h0,
            iacl_pkg::AXI_SLVERR);
        // second reset in mid-run
        wr(iacl_pkg::OFF_CTRL, 32'h7, iacl_pkg::AXI_OKAY);
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        @(posedge clk);
        rdchk(iacl_pkg::OFF_CTRL, 32'h7, 32'h0, 2'h0);
        `CHK(drive, 1'b0)
        tally_and_finish();
    end
endmodule : tb_i2c_ack_and_latch_clear
`default_nettype wire
